// file: logic/pmu_top.sv
// Four-event-counter performance monitor with coprocessor access
`include "pmu_defines.svh"
`default_nettype none
module pmu_top (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  cp_wr,
    input  wire logic                  cp_rd,
    input  wire logic [3:0]            cp_sel,
    input  wire pmu_pkg::pmu_word_t    cp_wdata,
    output pmu_pkg::pmu_word_t         cp_rdata,
    input  wire logic [`PMU_NSRC-1:0]  ev_src,
    output logic                       irq
);
    logic                      enable_r;
    logic                      div_r;
    logic [`PMU_DIV_W-1:0]     presc_r;
    pmu_pkg::pmu_word_t        cycle_r;
    pmu_pkg::pmu_word_t        evcnt_r [4];
    logic [`PMU_NBITS-1:0]     irq_en_r;
    logic [`PMU_NBITS-1:0]     flags_r;
    pmu_pkg::pmu_word_t        evsel_r;
    logic [3:0]                ev_hit;
    logic                      cyc_tick;
    logic [`PMU_NBITS-1:0]     ovf_set;

    // Write strobes per register
    function automatic logic wsel(input logic [3:0] s);
        return cp_wr && cp_sel == s;
    endfunction

    // Control bits; divider and enable kept, resets are pulses
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enable_r <= 1'b0;
            div_r    <= 1'b0;
        end else if (wsel(`PMU_REG_CONTROL)) begin
            enable_r <= cp_wdata[`PMU_CTL_ENABLE];
            div_r    <= cp_wdata[`PMU_CTL_DIV];
        end
    end

    // Prescaler runs only while enabled, saving toggles when idle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            presc_r <= '0;
        end else if (!enable_r) begin
            presc_r <= '0;
        end else begin
            presc_r <= presc_r + 1'b1;
        end
    end

    // Tick per clock, or once per 64 when divided
    assign cyc_tick = enable_r &&
                      (!div_r || presc_r == `PMU_DIV_W'(`PMU_DIV_COUNT-1));

    // Cycle counter: write load, reset pulse, free wrap
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cycle_r <= '0;
        end else if (wsel(`PMU_REG_CYCLE)) begin
            cycle_r <= cp_wdata;
        end else if (wsel(`PMU_REG_CONTROL) && cp_wdata[`PMU_CTL_CYCRST]) begin
            cycle_r <= '0;
        end else if (cyc_tick) begin
            cycle_r <= cycle_r + 32'h1;
        end
    end

    // Per-counter event selection
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ev
            pmu_event_mux u_mux (
                .ref_clk (ref_clk),
                .rst     (rst),
                .src     (ev_src),
                .code    (evsel_r[8*g +: 8]),
                .hit     (ev_hit[g])
            );

            // Event counter; idle when globally disabled
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    evcnt_r[g] <= '0;
                end else if (wsel(4'(`PMU_REG_EVCNT0 + g))) begin
                    evcnt_r[g] <= cp_wdata;
                end else if (wsel(`PMU_REG_CONTROL) &&
                             cp_wdata[`PMU_CTL_EVRST]) begin
                    evcnt_r[g] <= '0;
                end else if (enable_r && ev_hit[g]) begin
                    evcnt_r[g] <= evcnt_r[g] + 32'h1;
                end
            end

            assign ovf_set[`PMU_EV_BIT0+g] = enable_r && ev_hit[g] &&
                       !wsel(4'(`PMU_REG_EVCNT0 + g)) &&
                       !(wsel(`PMU_REG_CONTROL) && cp_wdata[`PMU_CTL_EVRST]) &&
                       evcnt_r[g] == 32'hFFFFFFFF;
        end
    endgenerate

    assign ovf_set[`PMU_CYC_BIT] = cyc_tick && cycle_r == 32'hFFFFFFFF &&
                 !wsel(`PMU_REG_CYCLE) &&
                 !(wsel(`PMU_REG_CONTROL) && cp_wdata[`PMU_CTL_CYCRST]);

    // Interrupt enables, upper bits dropped
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_en_r <= '0;
        end else if (wsel(`PMU_REG_IRQ_EN)) begin
            irq_en_r <= cp_wdata[`PMU_NBITS-1:0];
        end
    end

    // Overflow flags; a new overflow beats a same-cycle clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags_r <= '0;
        end else if (wsel(`PMU_REG_FLAGS)) begin
            flags_r <= (flags_r & ~cp_wdata[`PMU_NBITS-1:0]) | ovf_set;
        end else begin
            flags_r <= flags_r | ovf_set;
        end
    end

    // Event selection codes, software must disable first
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evsel_r <= {4{`PMU_EV_OFF}};
        end else if (wsel(`PMU_REG_EVSEL)) begin
            evsel_r <= cp_wdata;
        end
    end

    // Request independent of global enable on purpose
    assign irq = |(flags_r & irq_en_r);

    // Registered read data; reset bits read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cp_rdata <= '0;
        end else if (cp_rd) begin
            unique case (cp_sel)
                `PMU_REG_CONTROL: cp_rdata <= {`PMU_ID_VALUE, 20'h0,
                                               div_r, 2'b00, enable_r};
                `PMU_REG_CYCLE:   cp_rdata <= cycle_r;
                `PMU_REG_IRQ_EN:  cp_rdata <= {27'h0, irq_en_r};
                `PMU_REG_FLAGS:   cp_rdata <= {27'h0, flags_r};
                `PMU_REG_EVSEL:   cp_rdata <= evsel_r;
                4'h8:             cp_rdata <= evcnt_r[0];
                4'h9:             cp_rdata <= evcnt_r[1];
                4'hA:             cp_rdata <= evcnt_r[2];
                4'hB:             cp_rdata <= evcnt_r[3];
                default:          cp_rdata <= '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: logic/pmu_defines.svh
// Register numbers, field positions, reset values and event codes
`ifndef PMU_DEFINES_SVH
`define PMU_DEFINES_SVH

// Register selectors on the coprocessor port
`define PMU_REG_CONTROL   4'h0
`define PMU_REG_CYCLE     4'h1
`define PMU_REG_IRQ_EN    4'h2
`define PMU_REG_FLAGS     4'h3
`define PMU_REG_EVSEL     4'h4
`define PMU_REG_EVCNT0    4'h8

// Control fields
`define PMU_CTL_ENABLE    0
`define PMU_CTL_EVRST     1
`define PMU_CTL_CYCRST    2
`define PMU_CTL_DIV       3
`define PMU_CTL_ID_LSB    24
`define PMU_CTL_ID_MSB    31
`define PMU_ID_VALUE      8'h5A

// Per-counter bit positions in enable and flag registers
`define PMU_CYC_BIT       0
`define PMU_EV_BIT0       1
`define PMU_NBITS         5

// Cycle prescale
`define PMU_DIV_COUNT     64
`define PMU_DIV_W         6

// Event codes
`define PMU_EV_OFF        8'hFF
`define PMU_NSRC          14

`endif

// file: logic/pmu_pkg.sv
// Types shared by the performance monitor
`default_nettype none
package pmu_pkg;
    typedef logic [31:0] pmu_word_t;
    typedef logic [7:0]  pmu_code_t;
endpackage
`default_nettype wire

// file: logic/pmu_event_mux.sv
// Event source selector and run-edge detector for one counter
`include "pmu_defines.svh"
`default_nettype none
module pmu_event_mux (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic [`PMU_NSRC-1:0]  src,
    input  wire pmu_pkg::pmu_code_t    code,
    output logic                       hit
);
    logic dbuf_prev_r;

    // Remember last-cycle buffer-full level for run counting
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dbuf_prev_r <= 1'b0;
        end else begin
            dbuf_prev_r <= src[8];
        end
    end

    // Source map; unknown codes and the off code never count
    always_comb begin
        hit = 1'b0;
        if (code < 8'h0E) begin
            if (code == 8'h09) begin
                hit = src[8] & ~dbuf_prev_r;
            end else begin
                hit = src[code[3:0]];
            end
        end else begin
            hit = 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: testbench/pmu_properties.sv
// Port-level properties of the performance monitor
`include "pmu_defines.svh"
`default_nettype none
module pmu_properties (
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire logic                 cp_wr,
    input wire logic                 cp_rd,
    input wire logic [3:0]           cp_sel,
    input wire pmu_pkg::pmu_word_t   cp_wdata,
    input wire pmu_pkg::pmu_word_t   cp_rdata,
    input wire logic [`PMU_NSRC-1:0] ev_src,
    input wire logic                 irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Write then read of one select two edges later
    sequence s_wr_rd(logic ok);
        cp_wr && ok ##1 !cp_wr ##1 cp_rd && !cp_wr && cp_sel == $past(cp_sel, 2);
    endsequence
    property p_id;
        cp_rd && cp_sel == 4'h0 |=> cp_rdata[31:4] == {`PMU_ID_VALUE, 20'h0};
    endproperty
    a_id: assert property (p_id) else $error("control id bad");
    property p_ctl;
        s_wr_rd(cp_sel == 4'h0) |=>
            cp_rdata[3:0] == ($past(cp_wdata[3:0], 3) & 4'h9);
    endproperty
    a_ctl: assert property (p_ctl) else $error("control bits");
    property p_unmap;
        cp_rd && cp_sel inside {[4'h5:4'h7], [4'hC:4'hF]} |=> cp_rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_ien_off;
        cp_wr && cp_sel == 4'h2 && cp_wdata[4:0] == 5'h0 |=> !irq;
    endproperty
    a_ien_off: assert property (p_ien_off) else $error("irq stuck");
    // Only enable or flag writes may withdraw a request
    property p_hold;
        irq && !(cp_wr && cp_sel inside {4'h2, 4'h3}) |=> irq;
    endproperty
    a_hold: assert property (p_hold) else $error("irq dropped");
    property p_rst;
        $fell(rst) |-> !irq && cp_rdata == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_evsel;
        s_wr_rd(cp_sel == 4'h4) |=> cp_rdata == $past(cp_wdata, 3);
    endproperty
    a_evsel: assert property (p_evsel) else $error("select lost");
    // One enabled edge can pass between load and read
    property p_load;
        s_wr_rd(cp_sel inside {4'h1, [4'h8:4'hB]}) |=>
            cp_rdata - $past(cp_wdata, 3) <= 32'h2;
    endproperty
    a_load: assert property (p_load) else $error("load lost");
    c_irq: cover property ($rose(irq));
    c_cyc: cover property (cp_rd && cp_sel == 4'h1);
    c_div: cover property (cp_wr && cp_sel == 4'h0 && cp_wdata[3]);
endmodule
bind pmu_top pmu_properties chk_u (.ref_clk(ref_clk), .rst(rst),
    .cp_wr(cp_wr), .cp_rd(cp_rd), .cp_sel(cp_sel), .cp_wdata(cp_wdata),
    .cp_rdata(cp_rdata), .ev_src(ev_src), .irq(irq));
`default_nettype wire

// file: testbench/pmu_core_model.sv
// Core-side model issuing coprocessor register transfers
`default_nettype none
module pmu_core_model (
    input  wire logic         ref_clk,
    input  wire pmu_pkg::pmu_word_t cp_rdata,
    output logic              cp_wr,
    output logic              cp_rd,
    output logic [3:0]        cp_sel,
    output pmu_pkg::pmu_word_t cp_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        cp_wr = 1'h0;
        cp_rd = 1'h0;
        cp_sel = 4'hF;
        cp_wdata = 32'h0;
    end
    // Released data shows its inverse, never the stale word
    task automatic wr(input logic [3:0] s, input pmu_pkg::pmu_word_t d);
        @(negedge ref_clk);
        {cp_wr, cp_sel, cp_wdata} = {1'h1, s, d};
        @(negedge ref_clk);
        {cp_wr, cp_wdata} = {1'h0, ~d};
    endtask
    task automatic rd(input logic [3:0] s, output pmu_pkg::pmu_word_t d);
        @(negedge ref_clk);
        {cp_rd, cp_sel} = {1'h1, s};
        @(negedge ref_clk);
        cp_rd = 1'h0;
        d = cp_rdata;
    endtask
    // Disable before touching the selection
    task automatic sel_ev(input pmu_pkg::pmu_word_t d);
        wr(4'h0, 32'h0);
        wr(4'h4, d);
    endtask
    // Disable and reset in separate writes
    task automatic clr;
        wr(4'h0, 32'h0);
        wr(4'h0, 32'h6);
    endtask
endmodule
`default_nettype wire

// file: testbench/four_counter_perf_monitor_tb_top.sv
// Self-checking bench for the performance monitor
`include "pmu_defines.svh"
`default_nettype none
module four_counter_perf_monitor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic w; logic [3:0] s; pmu_pkg::pmu_word_t d, e;
    } pmu_row_t;
    logic ref_clk = 1'h0, rst = 1'h1, cp_wr, cp_rd, irq;
    logic [3:0] cp_sel;
    pmu_pkg::pmu_word_t cp_wdata, cp_rdata, v;
    logic [`PMU_NSRC-1:0] ev_src = '0;
    int error_cnt = 0, cmp_count = 0;
    pmu_row_t rows [10] = '{
        '{1'h0, 4'h0, 32'h0, 32'h5A000000}, '{1'h0, 4'h2, 32'h0, 32'h0},
        '{1'h0, 4'h3, 32'h0, 32'h0}, '{1'h0, 4'h4, 32'h0, 32'hFFFFFFFF},
        '{1'h1, 4'h0, 32'hFFFFFFF8, 32'h5A000008},
        '{1'h1, 4'h2, 32'hFFFFFFE0, 32'h0}, '{1'h1, 4'h3, 32'hFFFFFFFF, 32'h0},
        '{1'h1, 4'h4, 32'h0C0B0A09, 32'h0C0B0A09},
        '{1'h1, 4'h5, 32'h12345678, 32'h0},
        '{1'h1, 4'hA, 32'h12345678, 32'h12345678}};
    pmu_top dut_u (.ref_clk(ref_clk), .rst(rst), .cp_wr(cp_wr), .cp_rd(cp_rd),
        .cp_sel(cp_sel), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata),
        .ev_src(ev_src), .irq(irq));
    pmu_core_model core_u (.ref_clk(ref_clk), .cp_rdata(cp_rdata),
        .cp_wr(cp_wr), .cp_rd(cp_rd), .cp_sel(cp_sel), .cp_wdata(cp_wdata));
    // Clock at 100 MHz
    always #5 ref_clk = ~ref_clk;
    task automatic chk(input pmu_pkg::pmu_word_t got, exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [3:0] s, input pmu_pkg::pmu_word_t e);
        core_u.rd(s, v);
        chk(v, e);
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog well beyond the under two hundred cycles needed
    initial begin
        #50000;
        error_cnt++;
        stop_test();
    end
    // Main sequence: table, then overflow, divider, resets
    initial begin
        repeat (3) @(negedge ref_clk);
        rst = 1'h0;
        foreach (rows[i]) begin
            if (rows[i].w) core_u.wr(rows[i].s, rows[i].d);
            rchk(rows[i].s, rows[i].e);
        end
        core_u.sel_ev(32'hFFFF0801);
        core_u.wr(4'h8, 32'hFFFFFFFF);
        core_u.wr(4'h2, 32'h2);
        ev_src = 14'h0102; // Held high while still disabled
        core_u.wr(4'h0, 32'h1);
        core_u.wr(4'h0, 32'h0);
        ev_src = 14'h0;
        rchk(4'h8, 32'h1);
        rchk(4'h9, 32'h2);
        rchk(4'hA, 32'h12345678);
        rchk(4'h3, 32'h2);
        chk({31'h0, irq}, 32'h1);
        core_u.wr(4'h2, 32'h0);
        chk({31'h0, irq}, 32'h0);
        core_u.wr(4'h2, 32'h2);
        core_u.wr(4'h3, 32'h2);
        chk({31'h0, irq}, 32'h0);
        // Exactly 64 enabled edges give one divided tick
        core_u.wr(4'h1, 32'hFFFFFFFF);
        core_u.wr(4'h0, 32'h9);
        repeat (62) @(negedge ref_clk);
        core_u.wr(4'h0, 32'h0);
        rchk(4'h1, 32'h0);
        rchk(4'h3, 32'h1);
        core_u.wr(4'h0, 32'h1);
        core_u.wr(4'h0, 32'h0);
        rchk(4'h1, 32'h2);
        core_u.clr();
        rchk(4'h1, 32'h0);
        rchk(4'h8, 32'h0);
        // Occurrence codes and a buffer-full run begun while counting
        core_u.sel_ev(32'h0A090D00);
        core_u.wr(4'h0, 32'h1);
        ev_src = 14'h2501; // Raised inside the enabled window
        core_u.wr(4'h0, 32'h0);
        ev_src = 14'h0;
        rchk(4'h8, 32'h2);
        rchk(4'h9, 32'h2);
        rchk(4'hA, 32'h1);
        rchk(4'hB, 32'h2);
        stop_test();
    end
endmodule
`default_nettype wire
